// >>> rtl/tcu_counter_defines.vh
// Constants for the sixteen-bit timer counter unit
`ifndef TCU_COUNTER_DEFINES_VH
`define TCU_COUNTER_DEFINES_VH

// -----------------------------------------------------------------
// I/O locations on the 8-bit processor bus
// -----------------------------------------------------------------
`define TCU_ADDR_CTRL_FIRST   4'h0
`define TCU_ADDR_CTRL_SECOND  4'h1
`define TCU_ADDR_COUNT_HI     4'h2
`define TCU_ADDR_COUNT_LO     4'h3
`define TCU_ADDR_CMPA_HI      4'h4
`define TCU_ADDR_CMPA_LO      4'h5
`define TCU_ADDR_CMPB_HI      4'h6
`define TCU_ADDR_CMPB_LO      4'h7
`define TCU_ADDR_CAPT_HI      4'h8
`define TCU_ADDR_CAPT_LO      4'h9

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define TCU_WGM_LO_MSB        1
`define TCU_CS_MSB            2
`define TCU_WGM_HI_LSB        3
`define TCU_WGM_HI_MSB        4
`define TCU_BYTE_ZERO         8'h00
`define TCU_WORD_ZERO         16'h0000
`define TCU_WORD_MAX          16'hFFFF
`define TCU_TOP_8BIT          16'h00FF
`define TCU_TOP_9BIT          16'h01FF
`define TCU_TOP_10BIT         16'h03FF

// -----------------------------------------------------------------
// Clock source select codes
// -----------------------------------------------------------------
`define TCU_CS_NONE           3'h0
`define TCU_CS_DIV1           3'h1
`define TCU_CS_DIV8           3'h2
`define TCU_CS_DIV64          3'h3
`define TCU_CS_DIV256         3'h4
`define TCU_CS_DIV1024        3'h5
`define TCU_CS_EXT_FALL       3'h6
`define TCU_CS_EXT_RISE       3'h7
`define TCU_PRESCALE_W        10

`endif

// >>> rtl/tcu_counter_unit.v
// Sixteen-bit up/down timer counter with byte-wide processor access
//
// Behaviour
// - Sixteen-bit counter able to count up and down.
// - Count visible through an upper-byte and a lower-byte I/O location.
// - Upper-byte location accesses the shared holding register, not the counter.
// - Reading the lower byte copies counter upper byte into holding register.
// - Writing lower byte loads holding byte plus written byte in one cycle.
// - Three-bit clock source field selects internal or external ticks.
// - Source field zero: no ticks, counter holds.
// - Count readable and writable whether or not ticks run.
// - Processor write wins over a coincident clear or count step.
// - Each tick clears, increments or decrements as the mode dictates.
// - Four-bit waveform mode split over both control registers sets sequence.
// - Overflow flag set where the mode says; offered as interrupt source.
// - Clear forces all sixteen counter bits to zero.
// - Ceiling indication when count reaches the sequence top.
// - Floor indication when count reaches zero.
// - Floor is 0x0000, maximum is 0xFFFF.
// - Top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture, per mode.
// - One holding register serves count, compare and capture registers.

`include "tcu_counter_defines.vh"

module tcu_counter_unit
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [3:0]  io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  input  wire        ext_clk_pin,
  input  wire        overflow_clear,
  output reg  [15:0] timer_count,
  output reg  [15:0] compare_a_value,
  output reg  [15:0] compare_b_value,
  output reg  [15:0] capture_value,
  output reg         count_down,
  output reg         ceiling_hit,
  output reg         floor_hit,
  output reg         count_overflow_flag
);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  reg  [7:0]  ctrl_first_reg;
  reg  [7:0]  ctrl_second_reg;
  reg  [7:0]  hold_reg;
  reg  [15:0] count_reg;
  reg  [15:0] count_next;
  reg  [15:0] cmpa_reg;
  reg  [15:0] cmpb_reg;
  reg  [15:0] capt_reg;
  reg         dir_down_reg;
  reg         dir_down_next;
  reg  [`TCU_PRESCALE_W-1:0] pre_reg;
  reg         ext_s1_reg;
  reg         ext_s2_reg;
  reg         ext_s3_reg;
  reg         tick;
  reg  [15:0] top_val;
  reg         dual_slope;
  reg         capt_is_top;
  reg         ovf_event;
  reg  [7:0]  rdata_next;

  wire [2:0] clk_sel;
  wire [3:0] wave_mode;
  wire       wr_count_lo;

  // Mode field spans both control registers
  assign clk_sel   = ctrl_second_reg[`TCU_CS_MSB:0];
  assign wave_mode = {ctrl_second_reg[`TCU_WGM_HI_MSB:`TCU_WGM_HI_LSB],
                      ctrl_first_reg[`TCU_WGM_LO_MSB:0]};
  assign wr_count_lo = io_wr && (io_addr == `TCU_ADDR_COUNT_LO);

  // -----------------------------------------------------------------
  // Tick generation
  // -----------------------------------------------------------------
  // Pin passes two flops before the edge detector looks at it
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      pre_reg    <= {`TCU_PRESCALE_W{1'b0}};
    end
    else
    begin
      ext_s1_reg <= ext_clk_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      // Prescaler idles at zero while stopped so restarts are repeatable
      if (clk_sel == `TCU_CS_NONE)
        pre_reg <= {`TCU_PRESCALE_W{1'b0}};
      else
        pre_reg <= pre_reg + 1'b1;
    end
  end

  // Tick selection; prescaler taps are a simple choice here
  always @*
  begin
    case (clk_sel)
      `TCU_CS_NONE:     tick = 1'b0;
      `TCU_CS_DIV1:     tick = 1'b1;
      `TCU_CS_DIV8:     tick = &pre_reg[2:0];
      `TCU_CS_DIV64:    tick = &pre_reg[5:0];
      `TCU_CS_DIV256:   tick = &pre_reg[7:0];
      `TCU_CS_DIV1024:  tick = &pre_reg[9:0];
      `TCU_CS_EXT_FALL: tick = ext_s3_reg && !ext_s2_reg;
      `TCU_CS_EXT_RISE: tick = !ext_s3_reg && ext_s2_reg;
      default:          tick = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Mode decode
  // -----------------------------------------------------------------
  always @*
  begin
    case (wave_mode)
      4'h1, 4'h5: top_val = `TCU_TOP_8BIT;
      4'h2, 4'h6: top_val = `TCU_TOP_9BIT;
      4'h3, 4'h7: top_val = `TCU_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_val = cmpa_reg;
      4'h8, 4'hA, 4'hC, 4'hE: top_val = capt_reg;
      default:    top_val = `TCU_WORD_MAX;
    endcase
    case (wave_mode)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: dual_slope = 1'b1;
      default: dual_slope = 1'b0;
    endcase
    case (wave_mode)
      4'h8, 4'hA, 4'hC, 4'hE: capt_is_top = 1'b1;
      default: capt_is_top = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Counter next state
  // -----------------------------------------------------------------
  // Direction turns at the ends of a dual-slope sequence
  always @*
  begin
    count_next    = count_reg;
    dir_down_next = dir_down_reg;
    ovf_event     = 1'b0;
    if (tick)
    begin
      if (dual_slope)
      begin
        if (count_reg >= top_val)
          dir_down_next = 1'b1;
        else if (count_reg == `TCU_WORD_ZERO)
        begin
          dir_down_next = 1'b0;
          ovf_event     = 1'b1;
        end
        if (dir_down_next)
          count_next = count_reg - 1'b1;
        else
          count_next = count_reg + 1'b1;
      end
      else
      begin
        dir_down_next = 1'b0;
        // Plain CTC modes flag overflow only at the absolute maximum
        if (wave_mode == 4'h4 || wave_mode == 4'hC)
          ovf_event = (count_reg == `TCU_WORD_MAX);
        else
          ovf_event = (count_reg == top_val);
        if (count_reg == top_val)
          count_next = `TCU_WORD_ZERO;
        else
          count_next = count_reg + 1'b1;
      end
    end
    // A processor write discards any step taken in the same cycle
    if (wr_count_lo)
    begin
      count_next = {hold_reg, io_wdata};
      ovf_event  = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Read data mux
  // -----------------------------------------------------------------
  // Compare registers read their upper byte directly, not via the holder
  always @*
  begin
    case (io_addr)
      `TCU_ADDR_CTRL_FIRST:  rdata_next = ctrl_first_reg;
      `TCU_ADDR_CTRL_SECOND: rdata_next = ctrl_second_reg;
      `TCU_ADDR_COUNT_HI:    rdata_next = hold_reg;
      `TCU_ADDR_COUNT_LO:    rdata_next = count_reg[7:0];
      `TCU_ADDR_CMPA_HI:     rdata_next = cmpa_reg[15:8];
      `TCU_ADDR_CMPA_LO:     rdata_next = cmpa_reg[7:0];
      `TCU_ADDR_CMPB_HI:     rdata_next = cmpb_reg[15:8];
      `TCU_ADDR_CMPB_LO:     rdata_next = cmpb_reg[7:0];
      `TCU_ADDR_CAPT_HI:     rdata_next = hold_reg;
      `TCU_ADDR_CAPT_LO:     rdata_next = capt_reg[7:0];
      default:               rdata_next = `TCU_BYTE_ZERO;
    endcase
  end

  // -----------------------------------------------------------------
  // Register file and counter
  // -----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_first_reg  <= `TCU_BYTE_ZERO;
      ctrl_second_reg <= `TCU_BYTE_ZERO;
      hold_reg        <= `TCU_BYTE_ZERO;
      count_reg       <= `TCU_WORD_ZERO;
      cmpa_reg        <= `TCU_WORD_ZERO;
      cmpb_reg        <= `TCU_WORD_ZERO;
      capt_reg        <= `TCU_WORD_ZERO;
      dir_down_reg    <= 1'b0;
    end
    else
    begin
      count_reg    <= count_next;
      dir_down_reg <= dir_down_next;
      // Low-byte read latches the upper byte for the later high read
      if (io_rd && io_addr == `TCU_ADDR_COUNT_LO)
        hold_reg <= count_reg[15:8];
      else if (io_rd && io_addr == `TCU_ADDR_CAPT_LO)
        hold_reg <= capt_reg[15:8];
      else if (io_wr && (io_addr == `TCU_ADDR_COUNT_HI ||
                         io_addr == `TCU_ADDR_CMPA_HI ||
                         io_addr == `TCU_ADDR_CMPB_HI ||
                         io_addr == `TCU_ADDR_CAPT_HI))
        hold_reg <= io_wdata;
      if (io_wr)
      begin
        case (io_addr)
          `TCU_ADDR_CTRL_FIRST:  ctrl_first_reg  <= io_wdata;
          `TCU_ADDR_CTRL_SECOND: ctrl_second_reg <= io_wdata;
          `TCU_ADDR_CMPA_LO:     cmpa_reg <= {hold_reg, io_wdata};
          `TCU_ADDR_CMPB_LO:     cmpb_reg <= {hold_reg, io_wdata};
          `TCU_ADDR_CAPT_LO:
          begin
            // Capture is writable only where it defines the top
            if (capt_is_top)
              capt_reg <= {hold_reg, io_wdata};
          end
          default: ;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Registered outputs
  // -----------------------------------------------------------------
  // Indications track the value the counter takes this edge
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      io_rdata            <= `TCU_BYTE_ZERO;
      timer_count         <= `TCU_WORD_ZERO;
      compare_a_value     <= `TCU_WORD_ZERO;
      compare_b_value     <= `TCU_WORD_ZERO;
      capture_value       <= `TCU_WORD_ZERO;
      count_down          <= 1'b0;
      ceiling_hit         <= 1'b0;
      floor_hit           <= 1'b1;
      count_overflow_flag <= 1'b0;
    end
    else
    begin
      io_rdata        <= io_rd ? rdata_next : `TCU_BYTE_ZERO;
      timer_count     <= count_next;
      compare_a_value <= cmpa_reg;
      compare_b_value <= cmpb_reg;
      capture_value   <= capt_reg;
      count_down      <= dir_down_next;
      ceiling_hit     <= (count_next == top_val);
      floor_hit       <= (count_next == `TCU_WORD_ZERO);
      // Setting wins over a clear in the same cycle
      if (ovf_event)
        count_overflow_flag <= 1'b1;
      else if (overflow_clear)
        count_overflow_flag <= 1'b0;
    end
  end

endmodule

// >>> sim/tcu_counter_checker.sv
// Port assertions for the timer counter unit
`include "tcu_counter_defines.vh"
module tcu_counter_checker (
  input logic        clk,
  input logic        sys_rst,
  input logic [3:0]  io_addr,
  input logic        io_wr,
  input logic        io_rd,
  input logic [7:0]  io_wdata,
  input logic [7:0]  io_rdata,
  input logic        overflow_clear,
  input logic [15:0] timer_count,
  input logic        ceiling_hit,
  input logic        floor_hit,
  input logic        count_overflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Helpers
  // ----------
  logic [2:0] cs_q;
  logic       lo_wr;
  // Source field is not a port, so mirror it from bus writes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cs_q <= `TCU_CS_NONE;
    else if (io_wr && io_addr == `TCU_ADDR_CTRL_SECOND)
      cs_q <= io_wdata[`TCU_CS_MSB:0];
  end
  assign lo_wr = io_wr && io_addr == `TCU_ADDR_COUNT_LO;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr_pair;
    io_wr && io_addr == `TCU_ADDR_COUNT_HI ##1 lo_wr;
  endsequence
  sequence s_rd_pair;
    io_rd && io_addr == `TCU_ADDR_COUNT_LO ##1 io_rd && io_addr == `TCU_ADDR_COUNT_HI;
  endsequence
  // ----------
  // Assertions
  // ----------
  chk_floor_level: assert property (floor_hit == (timer_count == `TCU_WORD_ZERO))
    else $error("floor indication disagrees with count");
  chk_rdata_idle: assert property (!$past(io_rd) |-> io_rdata == `TCU_BYTE_ZERO)
    else $error("read data not zero outside a read");
  chk_wr_pair: assert property
    (s_wr_pair |=> timer_count == {$past(io_wdata, 2), $past(io_wdata)})
    else $error("word write not loaded whole");
  chk_rd_low: assert property
    (io_rd && io_addr == `TCU_ADDR_COUNT_LO |=> io_rdata == $past(timer_count[7:0]))
    else $error("low byte read wrong");
  chk_rd_pair: assert property (s_rd_pair |=> io_rdata == $past(timer_count[15:8], 2))
    else $error("upper byte not taken from holding copy");
  chk_stop_hold: assert property
    (cs_q == `TCU_CS_NONE && !lo_wr |=> timer_count == $past(timer_count))
    else $error("count moved with no source");
  chk_step_size: assert property
    (cs_q == `TCU_CS_DIV1 && $past(cs_q) == `TCU_CS_DIV1 && !lo_wr |=>
      timer_count == $past(timer_count) + 16'h0001 ||
      timer_count == $past(timer_count) - 16'h0001 || timer_count == `TCU_WORD_ZERO)
    else $error("count step not one");
  chk_ovf_sticky: assert property
    (count_overflow_flag && !overflow_clear |=> count_overflow_flag)
    else $error("overflow flag dropped");
  chk_ovf_point: assert property
    ($rose(count_overflow_flag) |-> floor_hit || $past(floor_hit))
    else $error("overflow flag set away from floor");
  chk_ovf_clear: assert property
    (overflow_clear && !floor_hit && !ceiling_hit && timer_count != `TCU_WORD_MAX
      |=> !count_overflow_flag)
    else $error("overflow flag not cleared");
endmodule

bind tcu_counter_unit tcu_counter_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .overflow_clear(overflow_clear),
  .timer_count(timer_count), .ceiling_hit(ceiling_hit), .floor_hit(floor_hit),
  .count_overflow_flag(count_overflow_flag)
);

// >>> sim/tcu_cpu_model.sv
// Processor core model: byte-wide bus master of the timer counter
module tcu_cpu_model (
  input  logic       clk,
  output logic [3:0] io_addr,
  output logic       io_wr,
  output logic       io_rd,
  output logic [7:0] io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] exp_q[$]; // Expected read bytes, oldest first
  // Bus starts idle
  initial
  begin
    io_addr = 4'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // One byte write; strobe stays up so calls run back to back
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    io_rd <= 1'b0;
  endtask
  // One byte read; data lines carry the inverted previous byte meanwhile
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= ~io_wdata;
    io_wr <= 1'b0;
    io_rd <= 1'b1;
    exp_q.push_back(e);
  endtask
  // Word write, upper byte first, never split by other accesses
  task wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo - 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  // Release the bus
  task idle();
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_wdata <= ~io_wdata;
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the timer counter unit
`include "tcu_counter_defines.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, ext_clk_pin, overflow_clear, io_wr, io_rd, rd_pend;
  logic        count_down, ceiling_hit, floor_hit, count_overflow_flag;
  logic [3:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, exp_b;
  logic [15:0] timer_count, compare_a_value, compare_b_value, capture_value;
  logic [31:0] rnd;
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;
  tcu_counter_unit DUT (
    .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .ext_clk_pin(ext_clk_pin),
    .overflow_clear(overflow_clear), .timer_count(timer_count),
    .compare_a_value(compare_a_value), .compare_b_value(compare_b_value),
    .capture_value(capture_value), .count_down(count_down), .ceiling_hit(ceiling_hit),
    .floor_hit(floor_hit), .count_overflow_flag(count_overflow_flag)
  );
  tcu_cpu_model cpu (
    .clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata)
  );
  // ----------
  // Run control
  // ----------
  task end_sim();
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task step();
    @(posedge clk);
    #1;
  endtask
  // Bounded wait for a count value
  task wait_for(input logic [15:0] v);
    for (int n = 0; n < 8 && timer_count !== v; n++)
      step();
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Read bytes checked against the oldest note; hang guard
  always @(posedge clk)
  begin
    if (rd_pend)
    begin
      exp_b = cpu.exp_q.pop_front();
      `CHK("read data", exp_b, io_rdata)
    end
    rd_pend <= io_rd;
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      err_total++;
      end_sim();
    end
  end
  // ----------
  // Scenarios
  // ----------
  initial
  begin
    rnd = $urandom(13997);
    rd_pend = 1'b0;
    sys_rst = 1'b1;
    ext_clk_pin = 1'b0;
    overflow_clear = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK("reset floor", 1'b1, floor_hit)
    cpu.wr16(`TCU_ADDR_COUNT_LO, 16'hFFFE);
    cpu.idle();
    repeat (20) step();
    `CHK("stopped", 16'hFFFE, timer_count)
    cpu.wr(`TCU_ADDR_CTRL_SECOND, {5'h00, `TCU_CS_DIV1});
    cpu.idle();
    #1;
    wait_for(`TCU_WORD_MAX);
    `CHK("top", 1'b1, ceiling_hit)
    step();
    `CHK("wrap", `TCU_WORD_ZERO, timer_count)
    `CHK("overflow", 1'b1, count_overflow_flag)
    // Write lands while ticking: the write must win
    cpu.wr16(`TCU_ADDR_COUNT_LO, 16'h1234);
    cpu.idle();
    #1;
    `CHK("write wins", 16'h1234, timer_count)
    step();
    `CHK("count up", 16'h1235, timer_count)
    @(posedge clk);
    overflow_clear <= 1'b1;
    @(posedge clk);
    overflow_clear <= 1'b0;
    #1;
    `CHK("flag clear", 1'b0, count_overflow_flag)
    cpu.wr(`TCU_ADDR_CTRL_SECOND, 8'h00);
    cpu.wr(`TCU_ADDR_CTRL_FIRST, 8'h01);
    cpu.wr16(`TCU_ADDR_COUNT_LO, 16'h00FE);
    cpu.wr(`TCU_ADDR_CTRL_SECOND, {5'h00, `TCU_CS_DIV1});
    cpu.idle();
    #1;
    wait_for(`TCU_TOP_8BIT);
    `CHK("fixed top", 1'b1, ceiling_hit)
    step();
    `CHK("turn down", 16'h00FE, timer_count)
    `CHK("direction", 1'b1, count_down)
    cpu.wr(`TCU_ADDR_CTRL_SECOND, 8'h00);
    cpu.wr(`TCU_ADDR_CTRL_FIRST, 8'h00);
    cpu.wr16(`TCU_ADDR_COUNT_LO, 16'h0500);
    cpu.wr(`TCU_ADDR_CTRL_SECOND, {5'h00, `TCU_CS_EXT_RISE});
    cpu.idle();
    repeat (3)
    begin
      repeat (4) @(posedge clk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk_pin <= 1'b0;
    end
    repeat (6) step();
    `CHK("pin edges", 16'h0503, timer_count)
    cpu.rd(`TCU_ADDR_COUNT_LO, 8'h03);
    cpu.rd(`TCU_ADDR_COUNT_HI, 8'h05);
    cpu.wr(`TCU_ADDR_COUNT_HI, 8'h77);
    cpu.rd(`TCU_ADDR_COUNT_HI, 8'h77);
    cpu.rd(4'hF, 8'h00);
    cpu.wr(`TCU_ADDR_COUNT_HI, 8'hAB);
    cpu.wr(`TCU_ADDR_COUNT_LO, 8'h12);
    cpu.wr(`TCU_ADDR_CMPA_LO, 8'h34);
    cpu.wr16(`TCU_ADDR_CMPB_LO, rnd[15:0]);
    cpu.rd(`TCU_ADDR_CMPB_HI, rnd[15:8]);
    cpu.idle();
    repeat (3) step();
    `CHK("count", 16'hAB12, timer_count)
    `CHK("compare a", 16'hAB34, compare_a_value)
    `CHK("compare b", rnd[15:0], compare_b_value)
    // Capture is refused outside the modes where it sets the top
    cpu.wr16(`TCU_ADDR_CAPT_LO, 16'h5A5A);
    cpu.idle();
    repeat (2) step();
    `CHK("capture refused", 16'h0000, capture_value)
    cpu.wr(`TCU_ADDR_CTRL_SECOND, 8'h18);
    cpu.wr16(`TCU_ADDR_CAPT_LO, 16'h0123);
    cpu.rd(`TCU_ADDR_CAPT_LO, 8'h23);
    cpu.rd(`TCU_ADDR_CAPT_HI, 8'h01);
    cpu.idle();
    repeat (3) step();
    `CHK("capture", 16'h0123, capture_value)
    // Capture value as top: clear after it, no overflow there
    cpu.wr16(`TCU_ADDR_COUNT_LO, 16'h0122);
    cpu.wr(`TCU_ADDR_CTRL_SECOND, 8'h19);
    cpu.idle();
    #1;
    wait_for(16'h0123);
    `CHK("capture top", 1'b1, ceiling_hit)
    step();
    `CHK("top clear", 16'h0000, timer_count)
    `CHK("no flag at top", 1'b0, count_overflow_flag)
    // Mid-run reset: control returns to no source, so the count stays at zero
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) step();
    `CHK("reset hold", 16'h0000, timer_count)
    `CHK("restart floor", 1'b1, floor_hit)
    end_sim();
  end
endmodule
